/* hdl/lcd_segment_common_scan.sv */
/*
  LCD scanner: holds 40 four-bit display bytes and drives 40 segment
  lines and up to four common lines (two in div2, three in div3) per time-division mode.
  Assumes a single clock, CPU-side memory writes synchronous to clk, and the
  scan clock arriving as an asynchronous pin that is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcd_scan_cfg.svh"
module lcd_segment_common_scan
  import lcd_scan_pkg::*;
#(
  parameter int SEGMENTS = `DMEM_BYTES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic lcd_scan_clock,
  input wire lcd_mode_e mode,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_hit,
  output logic [SEGMENTS-1:0] segment_select,
  output logic [3:0] common_select,
  output logic [3:0] common_oe,
  output logic [1:0] slot
);
  localparam int SLOT_CYCLES = (`SLOT_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // Refuse parameter values that the memory and slot logic cannot serve
  if (SEGMENTS < 1 || SEGMENTS > `DMEM_BYTES) begin : g_bad_segments
    $error("SEGMENTS out of range");
  end
  if (SLOT_CYCLES < 1) begin : g_bad_slot
    $error("slot period below one cycle");
  end

  // Index of a byte inside the window; segment n sits at last address minus n
  function automatic logic [5:0] seg_index(input logic [15:0] a);
    logic [15:0] d;
    d = `DMEM_LAST_ADDR - a;
    seg_index = d[5:0];
  endfunction : seg_index

  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= `DMEM_FIRST_ADDR) && (a <= `DMEM_LAST_ADDR);
  endfunction : in_window

  logic [`DMEM_DATA_BITS-1:0] dmem_q [0:`DMEM_BYTES-1];
  logic sync1_q, sync2_q, sync3_q;
  logic tick;
  logic [1:0] slot_q;
  logic frame_end;
  lcd_mode_e mode_q;
  common_bus_s com_d, com_q;
  logic [SEGMENTS-1:0] seg_d;
  logic [SEGMENTS-1:0] seg_q;

  assign mem_hit = in_window(mem_addr);

  // Only the low nibble is stored; the upper bits are simply dropped
  always_ff @(posedge clk) begin
    if (ce && mem_we && in_window(mem_addr)) begin
      dmem_q[seg_index(mem_addr)] <= mem_wdata[`DMEM_DATA_BITS-1:0];
    end
  end

  // Read data is registered; upper nibble always zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rdata <= 8'h00;
    end else if (ce) begin
      mem_rdata <= in_window(mem_addr) ? {4'h0, dmem_q[seg_index(mem_addr)]} : 8'h00;
    end
  end

  // Scan clock is a pin: two flops, then a third for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= lcd_scan_clock;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign tick = sync2_q && !sync3_q;

  // Mode is sampled only at frame boundaries so a frame never mixes modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= lcd_mode_e'(`MODE_RESET);
    end else if (ce && frame_end) begin
      mode_q <= mode;
    end
  end

  lcd_slot_counter u_slot (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .mode(mode_q),
    .slot_q(slot_q),
    .frame_end(frame_end)
  );

  always_comb begin
    com_d.level = 4'h0;
    com_d.oe = 4'h0;
    case (mode_q)
      MODE_STATIC: begin
        com_d.level = 4'hf;
        com_d.oe = 4'hf;
      end
      MODE_DIV2: begin
        com_d.level = 4'h1 << slot_q;
        com_d.oe = 4'h3;
      end
      MODE_DIV3: begin
        com_d.level = 4'h1 << slot_q;
        com_d.oe = 4'h7;
      end
      MODE_DIV4: begin
        com_d.level = 4'h1 << slot_q;
        com_d.oe = 4'hf;
      end
      default: begin
        com_d.level = 4'h0;
        com_d.oe = 4'h0;
      end
    endcase
  end

  // Static reads bit 0; other modes read the slot's bit, which never reaches
  // bits beyond the mode's last slot, so those bits are ignored
  genvar g;
  generate
    for (g = 0; g < SEGMENTS; g++) begin : g_seg
      always_comb begin
        if (mode_q == MODE_STATIC) begin
          seg_d[g] = dmem_q[g][0];
        end else begin
          seg_d[g] = dmem_q[g][slot_q];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      com_q <= '0;
      seg_q <= '0;
    end else if (ce) begin
      com_q <= com_d;
      seg_q <= seg_d;
    end
  end

  assign common_select = com_q.level;
  assign common_oe = com_q.oe;
  assign segment_select = seg_q;
  assign slot = slot_q;

  property p_static_commons;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_q == MODE_STATIC && $stable(mode_q)) |=> (common_select == 4'hf);
  endproperty
  a_static_commons: assert property (p_static_commons) else $error("static commons differ");

  property p_div2_open;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_q == MODE_DIV2) |=> (common_oe[3:2] == 2'b00 || $past(mode_q) != MODE_DIV2);
  endproperty
  a_div2_open: assert property (p_div2_open) else $error("div2 drives upper commons");

  property p_div3_open;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_q == MODE_DIV3) |=> (common_oe == 4'h7 || $past(mode_q) != MODE_DIV3);
  endproperty
  a_div3_open: assert property (p_div3_open) else $error("div3 drives common 3");

  property p_seg_follows_bit;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_q != MODE_STATIC) |=> (segment_select[0] == $past(dmem_q[0][slot_q]));
  endproperty
  a_seg_follows_bit: assert property (p_seg_follows_bit) else $error("segment 0 mismatch");

  property p_static_slot0_select_bit;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_q == MODE_STATIC) |=> (segment_select[0] == $past(dmem_q[0][0]));
  endproperty
  a_static_slot0_select_bit: assert property (p_static_slot0_select_bit) else $error("static uses wrong bit");

  property p_one_hot_common;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_q == MODE_DIV4 && $past(mode_q) == MODE_DIV4) |=> $onehot(common_select);
  endproperty
  a_one_hot_common: assert property (p_one_hot_common) else $error("div4 not one-hot");

  property p_slot_bound;
    @(posedge clk) disable iff (!rst_n)
    (mode_q == MODE_DIV3) |-> (slot_q <= 2'h2 || $changed(mode_q));
  endproperty
  a_slot_bound: assert property (p_slot_bound) else $error("div3 slot above 2");

  property p_rdata_high_zero;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |-> (mem_rdata[7:4] == 4'h0);
  endproperty
  a_rdata_high_zero: assert property (p_rdata_high_zero) else $error("upper nibble nonzero");

  property p_slot_hold;
    @(posedge clk) disable iff (!rst_n)
    (ce && !tick) |=> $stable(slot_q);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot moved without tick");
endmodule : lcd_segment_common_scan
`default_nettype wire

/* hdl/lcd_slot_counter.sv */
/*
  Common slot sequencer: advances one slot per scan tick and wraps after
  the number of slots in the chosen mode.
  Assumes the scan tick is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_slot_counter
  import lcd_scan_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire lcd_mode_e mode,
  output logic [1:0] slot_q,
  output logic frame_end
);
  function automatic logic [1:0] last_slot(input lcd_mode_e m);
    case (m)
      MODE_STATIC: last_slot = 2'h0;
      MODE_DIV2: last_slot = 2'h1;
      MODE_DIV3: last_slot = 2'h2;
      default: last_slot = 2'h3;
    endcase
  endfunction : last_slot

  // A mode change mid-frame past the new last slot restarts at slot 0
  assign frame_end = tick && (slot_q >= last_slot(mode));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_q <= 2'h0;
    end else if (ce && tick) begin
      slot_q <= frame_end ? 2'h0 : slot_q + 2'h1;
    end
  end

  property p_wrap;
    @(posedge clk) disable iff (!rst_n)
    (ce && frame_end) |=> (slot_q == 2'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("slot did not wrap at frame end");
endmodule : lcd_slot_counter
`default_nettype wire

/* shared/lcd_scan_cfg.svh */
/*
  Constants for the LCD segment/common scanner: memory window, field positions,
  reset values and slot timing.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef LCD_SCAN_CFG_SVH
`define LCD_SCAN_CFG_SVH
`define DMEM_FIRST_ADDR 16'hfa58
`define DMEM_LAST_ADDR 16'hfa7f
`define DMEM_BYTES 40
`define DMEM_DATA_BITS 4
`define SLOT_PERIOD_NS 100
`define CLK_PERIOD_NS 100
`define MODE_RESET 2'h3
`endif

/* shared/lcd_scan_pkg.sv */
/*
  Types shared by the LCD scanner: display modes and the common-line bundle.
  Assumes the _cfg header lives beside this file.
*/
`include "lcd_scan_cfg.svh"
package lcd_scan_pkg;
  typedef enum logic [1:0] {
    MODE_STATIC = 2'b00,
    MODE_DIV2 = 2'b01,
    MODE_DIV3 = 2'b10,
    MODE_DIV4 = 2'b11
  } lcd_mode_e;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } common_bus_s;
endpackage : lcd_scan_pkg

/* testbench/lcd_panel_model.sv */
/*
  Passive panel model: a segment pixel lights while a driven common selects.
  Assumes scanner outputs wire straight to it.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input wire logic [39:0] seg,
  input wire logic [3:0] com,
  input wire logic [3:0] oe,
  output logic [39:0] lit
);
  // Open commons carry no drive, so they light nothing
  assign lit = |(com & oe) ? seg : 40'h0;
endmodule : lcd_panel_model
`default_nettype wire

/* testbench/lcd_segment_common_scan_tb_top.sv */
/*
  Bench for the LCD scanner: fills display memory, scans every mode.
  Assumes a 10 MHz clock and a registered one-strobe write port.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_common_scan_tb_top;
  import lcd_scan_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, pin = 0, mem_we = 0, mem_hit;
  lcd_mode_e mode = MODE_DIV4;
  logic [15:0] mem_addr = 16'hfa58;
  logic [7:0] mem_wdata = 8'h00, mem_rdata;
  logic [39:0] seg, lit;
  logic [3:0] com, oe, mem_q [40];
  logic [1:0] slot;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  lcd_segment_common_scan lcd_segment_common_scan_inst (.clk(clk), .rst_n(rst_n),
    .ce(ce), .lcd_scan_clock(pin), .mode(mode), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
    .segment_select(seg), .common_select(com), .common_oe(oe), .slot(slot));
  lcd_panel_model lcd_panel_model_inst (.seg(seg), .com(com), .oe(oe), .lit(lit));
  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic do_reset();
    rst_n = 0;
    repeat (16) @(negedge clk);
    chk("reset outputs", 40'h0, seg | 40'({com, oe, slot}));
    rst_n = 1;
  endtask : do_reset
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic hit;
    hit = a >= 16'hfa58 && a <= 16'hfa7f;
    mem_addr = a;
    mem_wdata = d;
    mem_we = 1;
    @(negedge clk);
    mem_we = 0;
    @(negedge clk);
    if (hit) mem_q[16'hfa7f - a] = d[3:0];
    chk("mem_hit", 40'(hit), 40'(mem_hit));
    chk("mem_rdata", 40'(hit ? {4'h0, d[3:0]} : 8'h00), 40'(mem_rdata));
  endtask : wr
  // High time well above the two synchroniser stages
  task automatic scan();
    pin = 1;
    repeat (4) @(negedge clk);
    pin = 0;
    repeat (4) @(negedge clk);
  endtask : scan
  task automatic run_mode(input int m);
    logic [39:0] e;
    int n, s;
    n = m + 1;
    s = 0;
    mode = lcd_mode_e'(m);
    do_reset();
    // First frame still runs in the reset mode; the new one lands at its end
    repeat (4) scan();
    for (int i = 0; i < 2 * n + 1; i++) begin
      scan();
      s = (s + 1) % n;
      for (int k = 0; k < 40; k++) e[k] = mem_q[k][s];
      chk("segments", e, seg);
      chk("commons", 40'(m == 0 ? 8'hff : {4'(1 << s), 4'((1 << n) - 1)}), 40'({com, oe}));
      chk("slot", 40'(s), 40'(slot));
      chk("panel", |(com & oe) ? e : 40'h0, lit);
    end
    $display("mode %0d scan test done", m);
  endtask : run_mode
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // Bytes are written while reset still holds: writes ignore reset, and the
  // segment assertions would otherwise compare bytes never written
  task automatic preload_mem();
    mem_we = 1;
    for (int n = 0; n < 40; n++) begin
      mem_addr = 16'hfa7f - 16'(n);
      mem_wdata = 8'h00;
      mem_q[n] = 4'h0;
      @(negedge clk);
    end
    mem_we = 0;
  endtask : preload_mem
  task automatic mem_test();
    for (int n = 0; n < 40; n++) wr(16'hfa7f - 16'(n), 8'(n * 7 + 8'h30));
    for (int i = 0; i < 8; i++) wr(16'hfa6f - 16'(i), 8'((8'haf >> i) & 8'h01));
    wr(16'hfa63, 8'hfd);
    wr(16'hfa6a, 8'h0e);
    wr(16'hfa80, 8'h05);
    wr(16'hfa57, 8'h0a);
    $display("memory test done");
  endtask : mem_test
  // Every divided mode leaves run_mode on slot 1; a frozen block must stay
  // there and must drop both the scan pulse and the write
  task automatic freeze_test();
    ce = 0;
    mem_addr = 16'hfa7f;
    mem_wdata = {4'h0, ~mem_q[0]};
    mem_we = 1;
    scan();
    mem_we = 0;
    ce = 1;
    repeat (2) @(negedge clk);
    chk("frozen slot", 40'(2'h1), 40'(slot));
    chk("frozen write", 40'({4'h0, mem_q[0]}), 40'(mem_rdata));
    $display("clock enable test done");
  endtask : freeze_test
  initial begin
    preload_mem();
    do_reset();
    mem_test();
    for (int m = 0; m < 4; m++) run_mode(m);
    freeze_test();
    complete_run();
  end
endmodule : lcd_segment_common_scan_tb_top
`default_nettype wire
